// ==== rtl/mem_map_pkg.sv ====
// package for the code-bank and data-memory address decoder
// assumes one core clock and a synchronous active-high reset
`default_nettype none
package mem_map_pkg;
    localparam logic [7:0] bank_sel_addr = 8'h84;
    localparam logic [7:0] stack_sfr_addr = 8'h81;
    localparam logic [7:0] bank_sel_reset = 8'h00;
    localparam logic [7:0] stack_reset = 8'h07;
    localparam logic [7:0] stack_step = 8'h01;
    localparam logic [7:0] lower_ram_top = 8'h7f;
    localparam logic [7:0] bit_region_base = 8'h20;
    localparam logic [7:0] bit_region_top = 8'h2f;
    localparam logic [7:0] reg_bank_top = 8'h1f;
    localparam logic [15:0] common_bank_top = 16'h7fff;
    localparam int fetch_lo = 0;
    localparam int fetch_hi = 1;
    localparam int const_lo = 4;
    localparam int const_hi = 5;
    localparam int rs_lo = 3;
    localparam int rs_hi = 4;
    localparam logic [1:0] bank_zero = 2'h0;

    typedef enum logic [2:0] {
        data_direct_type = 3'h1,
        data_indirect_type = 3'h2,
        data_bit_type = 3'h4
    } data_mode_type;

    typedef struct packed {
        logic [16:0] flash_addr;
        logic reserved;
        logic lock;
    } flash_route_type;
endpackage
`default_nettype wire

// ==== rtl/flash_bank_map.sv ====
// maps a 16-bit code address onto the banked flash space
// assumes the caller provides the bank field that applies to the access
`timescale 1ns/1ps
`default_nettype none
module flash_bank_map
    import mem_map_pkg::*;
#(
    parameter logic [16:0] lock_addr = 17'h1ffff
) (
    input wire logic [15:0] i_addr, // logical code address
    input wire logic [1:0] i_bank, // selected upper bank
    output var flash_route_type o_route // physical address and flags
);
    wire upper_half = i_addr > common_bank_top;
    // bank zero appears low whatever the bank field says [R1]
    wire [1:0] eff_bank = upper_half ? i_bank : bank_zero; // [R2] [R4]
    wire [16:0] phys = {eff_bank, i_addr[14:0]};
    wire is_lock = phys == lock_addr; // [R8]
    wire is_reserved = phys > lock_addr; // [R8]
    // one driver for the whole struct keeps strict tools content
    assign o_route = {phys, is_reserved, is_lock};
endmodule
`default_nettype wire

// ==== rtl/mem_map_decoder.sv ====
// address decoder for code banking and the data-memory map
// assumes the core presents one access per cycle with an opcode-class strobe
// Functional notes
// R1 - common bank zero always at code 0x0000-0x7fff
// R2 - fetches above 0x7fff use the fetch bank field
// R3 - fetch bank field changes only when writer runs from bank zero
// R4 - constant reads and flash moves above 0x7fff use constant bank field
// R5 - bank select register at sfr 0x84, all pages, resets zero
// R6 - reserved fields read zero; software writes zero
// R7 - software avoids unimplemented banks on smaller variants
// R8 - last flash byte is the lock byte; above it reserved
// R9 - code reads hit flash; external moves hit xram or flash if redirected
// R10 - internal ram is 256 bytes; lower half direct and indirect
// R11 - above 0x7f direct goes to sfrs, indirect to upper ram
// R12 - 0x00-0x1f hold four register banks chosen by status bits 3,4
// R13 - indirect addressing uses index registers zero and one
// R14 - bytes 0x20-0x2f form bit addresses 0x00-0x7f
// R15 - bit or byte access chosen only by instruction type; o_bit_access also needs the bit address below 0x80
// R16 - stack pointer marks last used; push writes at pointer plus one
// R17 - stack pointer resets to 0x07
// R18 - stack pointer is eight bits, wraps within internal ram
// R19 - xram reached by data pointer or page register plus index
// R20 - eight-bit moves take high byte from page register
// R21 - bank field 00..11 selects 0x00..0x18 base
// R22 - external moves go to xram unless redirected to flash
// R23 - pop reads at pointer then decrements
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder
    import mem_map_pkg::*;
#(
    parameter logic [16:0] lock_addr = 17'h1ffff,
    parameter int xram_bits = 13
) (
    input wire logic i_clk_sys, // core clock
    input wire logic i_rst, // sync reset, active high
    input wire logic [15:0] i_fetch_addr, // instruction fetch address
    input wire logic [15:0] i_code_read_addr, // code_read_op address; flash moves use the data pointer pair
    input wire logic i_sfr_wr, // sfr write strobe
    input wire logic i_sfr_rd, // sfr read strobe
    input wire logic [7:0] i_sfr_addr, // sfr address
    input wire logic [7:0] i_sfr_wdata, // sfr write data
    input wire logic [15:0] i_exec_pc, // pc of writing instruction
    input wire logic [7:0] i_program_status_word, // core status word
    input wire logic [7:0] i_data_addr, // direct address or bit address
    input wire data_mode_type i_data_mode, // direct, indirect or bit
    input wire logic i_indirect_sel, // 0 index_reg_zero, 1 index_reg_one
    input wire logic [7:0] i_index_value, // content of selected index reg
    input wire logic i_push, // stack push
    input wire logic i_pop, // stack pop
    input wire logic i_ext_move, // external_move_op access
    input wire logic i_ext_short, // 8-bit form via index register
    input wire logic i_flash_redirect, // move redirected to flash
    input wire logic [15:0] i_data_pointer_pair, // 16-bit data pointer
    input wire logic [7:0] i_xram_page_register, // xram page byte
    output logic [16:0] o_fetch_flash_addr, // physical fetch address
    output logic o_fetch_reserved, // fetch above lock byte
    output logic [16:0] o_const_flash_addr, // physical constant address
    output logic o_const_lock, // constant access hits lock byte
    output logic o_const_reserved, // constant access reserved
    output logic [7:0] o_sfr_rdata, // sfr read data
    output logic o_sfr_hit, // sfr address is bank select
    output logic [7:0] o_program_bank_select, // bank select register
    output logic [7:0] o_stack_pointer, // stack pointer
    output logic [7:0] o_ram_addr, // internal ram byte address
    output logic o_ram_upper, // upper indirect ram selected
    output logic o_sfr_space, // direct access to sfr space
    output logic [2:0] o_bit_pos, // bit within byte for bit access
    output logic o_bit_access, // bit access in progress
    output logic [7:0] o_index_reg_addr, // ram address of index register
    output logic [15:0] o_xram_addr, // xram address
    output logic o_xram_sel, // move targets xram
    output logic o_flash_move // move targets flash
);
    logic [7:0] bank_sel_r;
    logic [7:0] bank_sel_nxt;
    logic [7:0] sp_r;
    logic [7:0] sp_nxt;
    flash_route_type fetch_route;
    flash_route_type const_route;

    // registers hold only the two fields; reserved bits never stored [R6]
    wire bank_sel_hit = i_sfr_addr == bank_sel_addr; // [R5]
    wire from_bank_zero = i_exec_pc <= common_bank_top;
    wire [1:0] fetch_bank = bank_sel_r[fetch_hi:fetch_lo];
    wire [1:0] const_bank = bank_sel_r[const_hi:const_lo];
    // a write from an upper bank keeps the old fetch field [R3]
    wire [1:0] fetch_new = from_bank_zero ? i_sfr_wdata[fetch_hi:fetch_lo] : fetch_bank;
    wire [1:0] const_new = i_sfr_wdata[const_hi:const_lo];

    always_comb begin
        bank_sel_nxt = bank_sel_r;
        if (i_sfr_wr && bank_sel_hit) begin
            bank_sel_nxt = bank_sel_reset;
            bank_sel_nxt[fetch_hi:fetch_lo] = fetch_new; // [R3]
            bank_sel_nxt[const_hi:const_lo] = const_new; // [R6]
        end
    end

    // push pre-increments, pop post-decrements; 8 bits wrap mod 256
    always_comb begin
        sp_nxt = sp_r;
        if (i_push && !i_pop) begin
            sp_nxt = sp_r + stack_step; // [R16] [R18]
        end else if (i_pop && !i_push) begin
            sp_nxt = sp_r - stack_step; // [R23] [R18]
        end
        if (i_sfr_wr && i_sfr_addr == stack_sfr_addr) begin
            sp_nxt = i_sfr_wdata;
        end
    end

    flash_bank_map #(
        .lock_addr(lock_addr)
    ) u_fetch_map (
        .i_addr(i_fetch_addr),
        .i_bank(fetch_bank), // [R2]
        .o_route(fetch_route)
    );

    // external moves
    wire ext_flash = i_ext_move && i_flash_redirect; // [R9]
    wire ext_xram = i_ext_move && !i_flash_redirect; // [R22]

    flash_bank_map #(
        .lock_addr(lock_addr)
    ) u_const_map (
        .i_addr(ext_flash ? i_data_pointer_pair : i_code_read_addr),
        .i_bank(const_bank), // [R4]
        .o_route(const_route)
    );

    // data-space decode
    wire is_bit = i_data_mode == data_bit_type; // [R15]
    wire is_indirect = i_data_mode == data_indirect_type;
    wire [7:0] bit_byte = bit_region_base + {4'h0, i_data_addr[6:3]}; // [R14]
    wire [7:0] direct_addr = is_bit ? bit_byte : i_data_addr;
    wire [7:0] eff_addr = is_indirect ? i_index_value : direct_addr; // [R13]
    wire above_lower = eff_addr > lower_ram_top;
    wire to_sfr = !is_indirect && above_lower; // [R11]
    wire to_upper = is_indirect && above_lower; // [R10] [R11]
    // bank base = field * 8, then the index register number [R12] [R21]
    wire [1:0] reg_bank = i_program_status_word[rs_hi:rs_lo];
    wire [7:0] index_addr = {3'h0, reg_bank, 2'h0, i_indirect_sel}; // [R13]

    // short form: page register high, index low [R19] [R20]
    wire [15:0] xram_full = i_ext_short ? {i_xram_page_register, i_index_value}
                                        : i_data_pointer_pair;
    wire [15:0] xram_mask = 16'hffff >> (16 - xram_bits);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bank_sel_r <= bank_sel_reset; // [R5]
            sp_r <= stack_reset; // [R17]
        end else begin
            bank_sel_r <= bank_sel_nxt;
            sp_r <= sp_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_fetch_flash_addr <= '0;
            o_fetch_reserved <= 1'b0;
            o_const_flash_addr <= '0;
            o_const_lock <= 1'b0;
            o_const_reserved <= 1'b0;
        end else begin
            o_fetch_flash_addr <= fetch_route.flash_addr; // [R1] [R2]
            o_fetch_reserved <= fetch_route.reserved; // [R8]
            o_const_flash_addr <= const_route.flash_addr; // [R4] [R9]
            o_const_lock <= const_route.lock; // [R8]
            o_const_reserved <= const_route.reserved; // [R8]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_sfr_rdata <= '0;
            o_sfr_hit <= 1'b0;
            o_program_bank_select <= bank_sel_reset;
            o_stack_pointer <= stack_reset;
        end else begin
            o_sfr_rdata <= (i_sfr_rd && bank_sel_hit) ? bank_sel_r : 8'h00; // [R6]
            o_sfr_hit <= bank_sel_hit;
            o_program_bank_select <= bank_sel_nxt;
            o_stack_pointer <= sp_nxt;
        end
    end

    // push address is pointer plus one, pop reads the pointer itself
    wire [7:0] stack_addr = i_push ? sp_r + stack_step : sp_r; // [R16] [R23]
    wire stack_op = i_push || i_pop;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ram_addr <= '0;
            o_ram_upper <= 1'b0;
            o_sfr_space <= 1'b0;
            o_bit_pos <= '0;
            o_bit_access <= 1'b0;
            o_index_reg_addr <= '0;
        end else begin
            o_ram_addr <= stack_op ? stack_addr : eff_addr; // [R10]
            o_ram_upper <= stack_op ? stack_addr > lower_ram_top : to_upper;
            o_sfr_space <= stack_op ? 1'b0 : to_sfr; // [R11]
            o_bit_pos <= i_data_addr[2:0]; // [R14]
            o_bit_access <= is_bit && !i_data_addr[7]; // [R15]
            o_index_reg_addr <= index_addr; // [R12]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_xram_addr <= '0;
            o_xram_sel <= 1'b0;
            o_flash_move <= 1'b0;
        end else begin
            o_xram_addr <= xram_full & xram_mask; // [R19]
            o_xram_sel <= ext_xram; // [R22]
            o_flash_move <= ext_flash; // [R9]
        end
    end
endmodule
`default_nettype wire

// ==== tb/core_stub.sv ====
// core-side stub: status word, data pointer pair and xram page held as the core holds them
// assumes the bench calls set between clock edges, never on the rising one
`timescale 1ns/1ps
`default_nettype none
module core_stub (
    output logic [7:0] o_psw, // status word
    output logic [15:0] o_data_pointer_pair, // data pointer pair
    output logic [7:0] o_page // xram page byte
);
    initial {o_psw, o_data_pointer_pair, o_page} = '0;
    task automatic set(input logic [7:0] p, input logic [15:0] d, input logic [7:0] g);
        {o_psw, o_data_pointer_pair, o_page} = {p, d, g};
    endtask
endmodule
`default_nettype wire

// ==== tb/mem_map_decoder_props.sv ====
// assertions on the decoder ports: banking, bank register, stack and data splits
// assumes the bind below; every output follows its cause by one clock
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder_props
    import mem_map_pkg::*;
(
    input wire logic i_clk_sys, // clock
    input wire logic i_rst, // reset
    input wire logic [15:0] i_fetch_addr, // fetch
    input wire logic i_sfr_wr, // write
    input wire logic [7:0] i_sfr_addr, // sfr addr
    input wire logic [15:0] i_exec_pc, // pc
    input wire logic [7:0] i_program_status_word, // status
    input wire logic [7:0] i_data_addr, // data addr
    input wire data_mode_type i_data_mode, // mode
    input wire logic i_indirect_sel, // index sel
    input wire logic i_push, // push
    input wire logic i_pop, // pop
    input wire logic [16:0] o_fetch_flash_addr, // fetch phys
    input wire logic [7:0] o_program_bank_select, // bank reg
    input wire logic [7:0] o_stack_pointer, // sp
    input wire logic o_sfr_space, // sfr
    input wire logic [7:0] o_index_reg_addr // index addr
);
    wire logic sp_load = i_sfr_wr && i_sfr_addr == 8'h81;
    wire logic quiet = !i_push && !i_pop;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    fetch_low_a: assert property (!i_fetch_addr[15] |=>
        o_fetch_flash_addr == {1'b0, $past(i_fetch_addr)}) else $error("low fetch moved");
    fetch_bank_a: assert property (i_fetch_addr[15] |=> o_fetch_flash_addr ==
        {$past(o_program_bank_select[1:0]), $past(i_fetch_addr[14:0])}) else $error("bad bank");
    bank_guard_a: assert property (i_sfr_wr && i_sfr_addr == 8'h84 && i_exec_pc[15] |=>
        $stable(o_program_bank_select[1:0])) else $error("fetch bank changed from upper");
    bank_rsvd_a: assert property ((o_program_bank_select & 8'hcc) == 8'h00)
        else $error("reserved bits set");
    sp_reset_a: assert property (disable iff (1'b0) i_rst |=>
        o_stack_pointer == 8'h07 && o_program_bank_select == 8'h00) else $error("reset value");
    sp_push_a: assert property (i_push && !i_pop && !sp_load |=>
        o_stack_pointer == $past(o_stack_pointer) + 8'h01) else $error("push step");
    sfr_split_a: assert property (quiet && i_data_mode == data_direct_type |=>
        o_sfr_space == $past(i_data_addr[7])) else $error("sfr split");
    index_reg_a: assert property (i_data_mode == data_indirect_type |=>
        o_index_reg_addr == {3'h0, $past(i_program_status_word[4:3]), 2'h0,
        $past(i_indirect_sel)}) else $error("index register address");
endmodule
bind mem_map_decoder mem_map_decoder_props i_props (.i_clk_sys, .i_rst, .i_fetch_addr,
    .i_sfr_wr, .i_sfr_addr, .i_exec_pc, .i_program_status_word, .i_data_addr, .i_data_mode,
    .i_indirect_sel, .i_push, .i_pop, .o_fetch_flash_addr, .o_program_bank_select,
    .o_stack_pointer, .o_sfr_space, .o_index_reg_addr);
`default_nettype wire

// ==== tb/code_bank_and_data_memory_map_tb.sv ====
// random self-checking bench for the decoder against a cycle model
// assumes outputs land one clock after the inputs that cause them
`timescale 1ns/1ps
`default_nettype none
module code_bank_and_data_memory_map_tb;
    import mem_map_pkg::*;
    // smaller lock byte so that banks two and three fall in the reserved range
    localparam logic [16:0] lock = 17'h0ffff;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sel = 1'b0, psh = 1'b0, pop = 1'b0;
    logic mv = 1'b0, sh = 1'b0, rdr = 1'b0, fres, lk, cres, xs, fm;
    logic e_fres, e_lk, e_cres, e_xs, e_fm, e_mv;
    logic [7:0] sa = '0, wd = '0, da = '0, ix = '0, ps, pg, c_ps, c_pg, rdata, bsel, sp;
    logic [7:0] mb = 8'h00, msp = 8'h07, e_rd, ra, ia, e_ra, e_ia;
    logic ru, ss, ba, hit, e_ru, e_ss, e_ba, e_hit;
    logic [2:0] bp, e_bp;
    logic [15:0] fa = '0, ca = '0, pc = '0, dp, c_dp, xa, cad, e_xa;
    logic [16:0] ff, cf, e_ff, e_cf;
    logic [31:0] r, q;
    data_mode_type md = data_direct_type;
    int n_fail = 0, n_tests = 0;
    core_stub i_core_stub (.o_psw(c_ps), .o_data_pointer_pair(c_dp), .o_page(c_pg));
    mem_map_decoder #(.lock_addr(lock)) i_mem_map_decoder (
        .i_clk_sys(clk), .i_rst(rst), .i_fetch_addr(fa), .i_code_read_addr(ca),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(sa), .i_sfr_wdata(wd), .i_exec_pc(pc),
        .i_program_status_word(c_ps), .i_data_addr(da), .i_data_mode(md),
        .i_indirect_sel(sel), .i_index_value(ix), .i_push(psh), .i_pop(pop), .i_ext_move(mv),
        .i_ext_short(sh), .i_flash_redirect(rdr), .i_data_pointer_pair(c_dp),
        .i_xram_page_register(c_pg), .o_fetch_flash_addr(ff), .o_fetch_reserved(fres),
        .o_const_flash_addr(cf), .o_const_lock(lk), .o_const_reserved(cres), .o_sfr_rdata(rdata),
        .o_sfr_hit(hit), .o_program_bank_select(bsel), .o_stack_pointer(sp), .o_ram_addr(ra),
        .o_ram_upper(ru), .o_sfr_space(ss), .o_bit_pos(bp), .o_bit_access(ba),
        .o_index_reg_addr(ia),
        .o_xram_addr(xa), .o_xram_sel(xs), .o_flash_move(fm));
    function automatic logic [16:0] phys(logic [15:0] a, logic [1:0] b);
        return a[15] ? {b, a[14:0]} : {1'b0, a};
    endfunction
    task automatic check(string nm, logic [16:0] seen, logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h758b09db));
        repeat (8) @(negedge clk);
        check("sp reset", sp, 8'h07);
        check("bank reset", bsel, 8'h00);
        rst = 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(negedge clk);
            if (n > 0) begin
                check("bank", bsel, mb);
                check("sp", sp, msp);
                check("fetch", ff, e_ff);
                check("fetch rsvd", fres, e_fres);
                check("const", cf, e_cf);
                check("lock", {cres, lk}, {e_cres, e_lk});
                check("target", {xs, fm}, {e_xs, e_fm});
                check("sfr read", rdata, e_rd);
                if (e_mv) check("xram", xa, e_xa);
                check("ram", {ru, ss, ra}, {e_ru, e_ss, e_ra});
                check("bit", {ba, bp}, {e_ba, e_bp});
                check("index", ia, e_ia);
                check("sfr hit", hit, e_hit);
            end
            r = $urandom;
            q = $urandom;
            wr = r[2:0] == 3'h0;
            rd = !wr && r[3];
            sa = r[4] ? 8'h84 : (r[5] ? 8'h81 : q[7:0]);
            // first half keeps to the software rules, second half probes the refusals
            wd = (n < 1500 && sa == 8'h84) ? q[15:8] & 8'h11 : q[15:8];
            pc = {r[6], q[30:16]};
            psh = r[7];
            pop = r[8];
            mv = r[9];
            sh = r[10];
            rdr = r[11];
            sel = r[12];
            da = q[7:0] ^ r[31:24];
            ix = r[23:16];
            md = r[14:13] == 2'h0 ? data_direct_type
                : (r[13] ? data_indirect_type : data_bit_type);
            fa = r[15] ? 16'hffff : 16'($urandom);
            ca = r[1] ? 16'hffff : 16'($urandom);
            ps = 8'($urandom);
            dp = 16'($urandom);
            pg = 8'($urandom);
            i_core_stub.set(ps, dp, pg);
            cad = (mv && rdr) ? dp : ca;
            e_ff = phys(fa, mb[1:0]);
            e_fres = e_ff > lock;
            e_cf = phys(cad, mb[5:4]);
            e_lk = e_cf == lock;
            e_cres = e_cf > lock;
            e_rd = (rd && sa == 8'h84) ? mb : 8'h00;
            e_xs = mv && !rdr;
            e_fm = mv && rdr;
            e_mv = mv;
            e_xa = (sh ? {pg, ix} : dp) & 16'h1fff;
            e_ia = {3'h0, ps[4:3], 2'h0, sel};
            e_ra = md == data_indirect_type ? ix : (md == data_bit_type ? 8'h20 + da[6:3] : da);
            e_ru = md == data_indirect_type && e_ra > 8'h7f;
            e_ss = md == data_direct_type && e_ra > 8'h7f;
            if (psh || pop) begin
                e_ra = psh ? msp + 8'h01 : msp;
                e_ru = e_ra > 8'h7f;
                e_ss = 1'b0;
            end
            e_bp = da[2:0];
            e_ba = md == data_bit_type && !da[7];
            e_hit = sa == 8'h84;
            if (wr && sa == 8'h84) mb = {2'h0, wd[5:4], 2'h0, pc[15] ? mb[1:0] : wd[1:0]};
            if (wr && sa == 8'h81) msp = wd;
            else if (psh && !pop) msp = msp + 8'h01;
            else if (pop && !psh) msp = msp - 8'h01;
        end
        end_of_test();
    end
endmodule
`default_nettype wire
